// ===== common/pin_mux_consts.vh
// Constants for the quad channel pin function multiplexer
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// Register byte offsets
`define REG_MODE 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08
`define REG_CFGMEM 8'h0C

// Channel function codes, two bits per channel
`define FN_UART 2'h0
`define FN_BITBANG 2'h1
`define FN_ENGINE 2'h2

// Control register fields
`define CFG_BELL_SEL 0
`define CFG_WAKE_EN 1
`define CFG_CONFIGURED 2

// Reset values
`define MODE_RESET 8'h00
`define CFG_RESET 3'h0

// Timing: configuration memory clock period
`define CFGMEM_CLK_NS 1000
`define CLK_PERIOD_NS 10
`define CFGMEM_HALF_CYC ((`CFGMEM_CLK_NS / `CLK_PERIOD_NS) / 2)

`endif

// ===== design/cfgmem_pins.v
// Configuration memory pin drivers, quiet during reset
`include "pin_mux_consts.vh"

module cfgmem_pins #(
	parameter HALF_CYC = `CFGMEM_HALF_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire sel,
	input wire dout,
	input wire dout_en,
	input wire cfgmem_data_i,
	output wire cfgmem_select_o,
	output wire cfgmem_select_oe,
	output wire cfgmem_clock_o,
	output wire cfgmem_clock_oe,
	output wire cfgmem_data_o,
	output wire cfgmem_data_oe,
	output reg din_q
);

	reg [15:0] div_q;
	reg clk_q;
	reg live_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 16'h0000;
			clk_q <= 1'b0;
			live_q <= 1'b0;
			din_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
			if (run && div_q == HALF_CYC[15:0] - 16'h0001) begin
				div_q <= 16'h0000;
				clk_q <= ~clk_q;
				// Sample on the rising clock edge of the memory
				if (!clk_q)
					din_q <= cfgmem_data_i; // see R13
			end else if (run) begin
				div_q <= div_q + 16'h0001;
			end else begin
				div_q <= 16'h0000;
				clk_q <= 1'b0;
			end
		end
	end

	// Enables fall with reset, without waiting for a clock edge
	assign cfgmem_select_o = sel;
	assign cfgmem_select_oe = live_q & aresetn; // see R11
	assign cfgmem_clock_o = clk_q;
	assign cfgmem_clock_oe = live_q & aresetn; // see R12
	assign cfgmem_data_o = dout;
	assign cfgmem_data_oe = live_q & aresetn & dout_en; // see R11 see R13

endmodule

// ===== design/chan_mux.v
// One channel's eight-line port function selector
`include "pin_mux_consts.vh"

module chan_mux #(
	parameter HAS_ENGINE = 1
) (
	input wire [1:0] fn,
	input wire bell_sel,
	input wire uart_txd,
	input wire uart_rts_n,
	input wire uart_dtr_n,
	input wire uart_line_driver_enable,
	input wire [7:0] bb_out,
	input wire [7:0] bb_oe,
	input wire eng_sck,
	input wire eng_dout,
	input wire eng_cs,
	input wire [3:0] eng_aux_out,
	input wire [3:0] eng_aux_oe,
	output reg [7:0] pin_o,
	output reg [7:0] pin_oe
);

	always @* begin
		pin_o = 8'h00;
		pin_oe = 8'h00;
		case (fn)
			`FN_BITBANG: begin
				pin_o = bb_out; // see R02
				pin_oe = bb_oe; // see R02
			end
			`FN_ENGINE: begin
				if (HAS_ENGINE != 0) begin
					pin_o = {eng_aux_out, eng_cs, 1'b0, eng_dout, eng_sck}; // see R03
					pin_oe = {eng_aux_oe, 4'hB}; // see R03
				end else begin
					// Channels without an engine fall back to serial
					pin_o = {uart_line_driver_enable, 2'h0, uart_dtr_n, 1'b0, uart_rts_n, 1'b0, uart_txd}; // see R04
					pin_oe = {~bell_sel, 7'h15}; // see R04
				end
			end
			default: begin
				// Bit 7 drives only when the bell input is not selected
				pin_o = {uart_line_driver_enable, 2'h0, uart_dtr_n, 1'b0, uart_rts_n, 1'b0, uart_txd}; // see R01
				pin_oe = {~bell_sel, 7'h15}; // see R01 see R06 see R16
			end
		endcase
	end

endmodule

// ===== design/quad_channel_pin_function_mux.v
// Quad channel pin function multiplexer with AXI4-Lite control
// What this block does
// R01: Serial mode maps transmit, receive, handshake, modem lines
// R02: Bit-bang makes all eight lines bidirectional
// R03: Engine mode drives clock, data, select; aux I/O
// R04: Only channels A and B have an engine
// R05: C and D stay independently serial or bit-bang
// R06: Bit 7 is bell input or driver enable
// R07: Bell low with wake enabled signals resume
// R08: Power enable low only when configured, awake
// R09: Suspend output low while link is suspended
// R10: Low reset input resets the whole device
// R11: Memory select and data tri-stated in reset
// R12: Memory clock tri-stated in reset, else driven; here still tri-stated until the first clock edge after reset ends
// R13: One data pin carries both memory directions
// R14: Blank or missing memory defaults to serial
// R15: Host setup command switches serial and bit-bang; here ignored in a cycle where a register write commits
// R16: Input pins never driven after mode change
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`include "pin_mux_consts.vh"

module quad_channel_pin_function_mux #(
	parameter CFGMEM_HALF = `CFGMEM_HALF_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire link_suspended,
	input wire cfgmem_present,
	input wire setup_valid,
	input wire [1:0] setup_chan,
	input wire setup_bitbang,
	input wire [3:0] uart_txd,
	input wire [3:0] uart_rts_n,
	input wire [3:0] uart_dtr_n,
	input wire [3:0] uart_line_driver_enable,
	output reg [3:0] uart_rxd,
	output reg [3:0] uart_cts_n,
	output reg [3:0] uart_dsr_n,
	output reg [3:0] carrier_detect_n,
	output reg [3:0] bell_wake_n,
	input wire [31:0] bb_out,
	input wire [31:0] bb_oe,
	output reg [31:0] bb_in,
	input wire [1:0] eng_sck,
	input wire [1:0] eng_dout,
	input wire [1:0] eng_cs,
	input wire [7:0] engine_aux_out,
	input wire [7:0] engine_aux_oe,
	output reg [1:0] eng_din,
	output reg [7:0] engine_aux_in,
	input wire [7:0] port_a_lines_i,
	output wire [7:0] port_a_lines_o,
	output wire [7:0] port_a_lines_oe,
	input wire [7:0] port_b_lines_i,
	output wire [7:0] port_b_lines_o,
	output wire [7:0] port_b_lines_oe,
	input wire [7:0] port_c_lines_i,
	output wire [7:0] port_c_lines_o,
	output wire [7:0] port_c_lines_oe,
	input wire [7:0] port_d_lines_i,
	output wire [7:0] port_d_lines_o,
	output wire [7:0] port_d_lines_oe,
	output reg resume_req,
	output reg power_enable_n,
	output reg suspend_n,
	input wire cfgmem_data_i,
	output wire cfgmem_select_o,
	output wire cfgmem_select_oe,
	output wire cfgmem_clock_o,
	output wire cfgmem_clock_oe,
	output wire cfgmem_data_o,
	output wire cfgmem_data_oe
);

	reg [7:0] mode_q;
	reg [2:0] cfg_q;
	reg [2:0] mem_q;
	reg aw_q;
	reg w_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire mem_din;
	wire [31:0] all_in;
	wire [31:0] all_o;
	wire [31:0] all_oe;
	integer i;
	wire bell_low;

	// Channel function with engine only legal on A and B
	function [1:0] legal_fn;
		input [1:0] f;
		input has_engine;
		begin
			if (f == `FN_ENGINE && !has_engine)
				legal_fn = `FN_UART;
			else if (f == 2'h3)
				legal_fn = `FN_UART;
			else
				legal_fn = f;
		end
	endfunction

	// Bell input only exists while the channel runs as a serial port
	function bell_live;
		input [1:0] f;
		input sel;
		begin
			bell_live = sel && (f == `FN_UART);
		end
	endfunction

	// Channel A occupies the low byte of every 32-bit pin vector
	assign all_in = {port_d_lines_i, port_c_lines_i, port_b_lines_i, port_a_lines_i};

	// Engine-capable muxes only on A and B, see R04
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ch
			chan_mux #(
				.HAS_ENGINE(g < 2 ? 1 : 0)
			) u_mux (
				.fn(mode_q[2*g+1:2*g]),
				.bell_sel(cfg_q[`CFG_BELL_SEL]),
				.uart_txd(uart_txd[g]),
				.uart_rts_n(uart_rts_n[g]),
				.uart_dtr_n(uart_dtr_n[g]),
				.uart_line_driver_enable(uart_line_driver_enable[g]),
				.bb_out(bb_out[8*g+7:8*g]),
				.bb_oe(bb_oe[8*g+7:8*g]),
				.eng_sck(g < 2 ? eng_sck[g % 2] : 1'b0),
				.eng_dout(g < 2 ? eng_dout[g % 2] : 1'b0),
				.eng_cs(g < 2 ? eng_cs[g % 2] : 1'b0),
				.eng_aux_out(g < 2 ? engine_aux_out[4*(g%2)+3:4*(g%2)] : 4'h0),
				.eng_aux_oe(g < 2 ? engine_aux_oe[4*(g%2)+3:4*(g%2)] : 4'h0),
				.pin_o(all_o[8*g+7:8*g]),
				.pin_oe(all_oe[8*g+7:8*g])
			);
		end
	endgenerate

	// Split the flat vectors back into the four published ports
	assign port_a_lines_o = all_o[7:0];
	assign port_a_lines_oe = all_oe[7:0];
	assign port_b_lines_o = all_o[15:8];
	assign port_b_lines_oe = all_oe[15:8];
	assign port_c_lines_o = all_o[23:16];
	assign port_c_lines_oe = all_oe[23:16];
	assign port_d_lines_o = all_o[31:24];
	assign port_d_lines_oe = all_oe[31:24];

	// Input routing; sinks follow their pins in every mode, only bell_wake_n is held high when not live
	always @* begin
		bb_in = all_in; // see R02
		for (i = 0; i < 4; i = i + 1) begin
			uart_rxd[i] = all_in[8*i+1]; // see R01
			uart_cts_n[i] = all_in[8*i+3];
			uart_dsr_n[i] = all_in[8*i+5];
			carrier_detect_n[i] = all_in[8*i+6];
			// Bit 7 of a bit-bang or engine port is data, never a wake source
			bell_wake_n[i] = bell_live(mode_q[2*i +: 2], cfg_q[`CFG_BELL_SEL])
				? all_in[8*i+7] : 1'b1; // see R06
		end
		// Engine A sits on port A, engine B on port B
		eng_din[0] = all_in[2]; // see R03
		eng_din[1] = all_in[10];
		engine_aux_in[3:0] = all_in[7:4];
		engine_aux_in[7:4] = all_in[15:12];
	end

	// Select doubles as the data drive enable, so the data line
	// is only driven while the memory is being addressed
	cfgmem_pins #(
		.HALF_CYC(CFGMEM_HALF)
	) u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(mem_q[0]),
		.sel(mem_q[1]),
		.dout(mem_q[2]),
		.dout_en(mem_q[1]),
		.cfgmem_data_i(cfgmem_data_i),
		.cfgmem_select_o(cfgmem_select_o),
		.cfgmem_select_oe(cfgmem_select_oe),
		.cfgmem_clock_o(cfgmem_clock_o),
		.cfgmem_clock_oe(cfgmem_clock_oe),
		.cfgmem_data_o(cfgmem_data_o),
		.cfgmem_data_oe(cfgmem_data_oe),
		.din_q(mem_din)
	);

	// Any live bell input held low asks for a wake
	assign bell_low = (bell_wake_n != 4'hF); // see R07

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin // see R10
			mode_q <= `MODE_RESET; // see R14
			cfg_q <= `CFG_RESET;
			mem_q <= 3'h0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
			power_enable_n <= 1'b1;
			suspend_n <= 1'b1;
			resume_req <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			// Both halves held: commit and raise the answer on this same edge
			if (aw_q && w_q) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case ({awaddr_q[7:2], 2'b00})
					`REG_MODE: begin
						if (wstrb_q[0]) begin
							// Each channel checked alone, see R04 see R05
							mode_q[1:0] <= legal_fn(wdata_q[1:0], 1'b1);
							mode_q[3:2] <= legal_fn(wdata_q[3:2], 1'b1);
							mode_q[5:4] <= legal_fn(wdata_q[5:4], 1'b0);
							mode_q[7:6] <= legal_fn(wdata_q[7:6], 1'b0);
						end
					end
					`REG_CFG: begin
						if (wstrb_q[0])
							cfg_q <= wdata_q[2:0];
					end
					`REG_CFGMEM: begin
						if (wstrb_q[0])
							mem_q <= wdata_q[2:0];
					end
					`REG_STATUS: begin
					end
					default: s_axi_bresp <= 2'h2;
				endcase
			end else if (setup_valid) begin
				// Host setup command sets serial or bit-bang from setup_bitbang
				mode_q[2*setup_chan +: 2] <= setup_bitbang ? `FN_BITBANG : `FN_UART; // see R15
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// Read data is registered; arready drops while an answer is pending
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case ({s_axi_araddr[7:2], 2'b00})
					`REG_MODE: s_axi_rdata <= {24'h000000, mode_q};
					`REG_CFG: s_axi_rdata <= {29'h00000000, cfg_q};
					`REG_CFGMEM: s_axi_rdata <= {28'h0000000, mem_din, mem_q};
					`REG_STATUS: s_axi_rdata <= {27'h0000000, cfgmem_present,
						resume_req, power_enable_n, suspend_n, link_suspended};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// Status outputs follow the link one cycle late
			suspend_n <= !link_suspended; // see R09
			power_enable_n <= link_suspended || !cfg_q[`CFG_CONFIGURED]; // see R08
			// Only serial channels with the bell input selected may wake the host
			resume_req <= link_suspended && cfg_q[`CFG_WAKE_EN] && bell_low; // see R07
		end
	end

endmodule

// ===== dv/far_side.sv
// Peripheral on one channel port, merged with the device drive
module far_side (
	input wire [7:0] dev_o,
	input wire [7:0] dev_oe,
	input wire [7:0] ext,
	output wire [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Backs off wherever the device drives, so no contention
	assign pin = (dev_o & dev_oe) | (ext & ~dev_oe);
endmodule

// ===== dv/pin_mux_asserts.sv
// Checker on the pin multiplexer's top-level ports
module pin_mux_asserts (
	input wire aclk,
	input wire aresetn,
	input wire cfgmem_select_oe,
	input wire cfgmem_clock_oe,
	input wire cfgmem_data_oe,
	input wire [31:0] bb_oe,
	input wire [7:0] port_c_lines_oe,
	input wire [7:0] port_d_lines_oe,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire link_suspended,
	input wire power_enable_n,
	input wire suspend_n,
	input wire resume_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_mem_quiet: assert property (disable iff (1'b0)
		!aresetn |-> !cfgmem_select_oe && !cfgmem_clock_oe && !cfgmem_data_oe)
		else $error("memory pins driven in reset");
	a_mem_release: assert property ($rose(aresetn) |-> !cfgmem_clock_oe)
		else $error("memory clock driven too early");
	// Input pins of C and D may only be driven under bit-bang enables
	a_c_inputs: assert property ((port_c_lines_oe & ~bb_oe[23:16] & 8'h6A) == 8'h00)
		else $error("port c input driven");
	a_d_inputs: assert property ((port_d_lines_oe & ~bb_oe[31:24] & 8'h6A) == 8'h00)
		else $error("port d input driven");
	a_read_answer: assert property (read_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stuck");
	a_power_off: assert property (link_suspended |=> power_enable_n)
		else $error("power enable active in suspend");
	a_suspend_track: assert property (1 |=> suspend_n == !$past(link_suspended))
		else $error("suspend output wrong");
	a_resume_gate: assert property (!link_suspended |=> !resume_req)
		else $error("resume while awake");
endmodule

bind quad_channel_pin_function_mux pin_mux_asserts pin_mux_asserts_inst (.*);

// ===== dv/tb_top.sv
// Testbench for the quad channel pin multiplexer
`include "pin_mux_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, link_suspended, cfgmem_present, setup_valid, setup_bitbang;
	logic cfgmem_data_i;
	logic [7:0] s_axi_awaddr, s_axi_araddr, engine_aux_out, engine_aux_oe;
	logic [31:0] s_axi_wdata, bb_out, bb_oe;
	logic [3:0] s_axi_wstrb, uart_txd, uart_rts_n, uart_dtr_n, uart_line_driver_enable;
	logic [1:0] setup_chan, eng_sck, eng_dout, eng_cs;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire resume_req, power_enable_n, suspend_n, cfgmem_select_o, cfgmem_select_oe;
	wire cfgmem_clock_o, cfgmem_clock_oe, cfgmem_data_o, cfgmem_data_oe;
	wire [1:0] s_axi_bresp, s_axi_rresp, eng_din;
	wire [31:0] s_axi_rdata, bb_in;
	wire [3:0] uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_n, bell_wake_n;
	wire [7:0] engine_aux_in, port_a_lines_i, port_a_lines_o, port_a_lines_oe;
	wire [7:0] port_b_lines_i, port_b_lines_o, port_b_lines_oe;
	wire [7:0] port_c_lines_i, port_c_lines_o, port_c_lines_oe;
	wire [7:0] port_d_lines_i, port_d_lines_o, port_d_lines_oe;
	logic [7:0] ext_a = 8'h3C, ext_b = 8'h5A, ext_c = 8'hE6, ext_d = 8'h99;
	int n_fail = 0;
	int num_checks = 0;

	far_side side_a (.dev_o(port_a_lines_o), .dev_oe(port_a_lines_oe), .ext(ext_a),
		.pin(port_a_lines_i));
	far_side side_b (.dev_o(port_b_lines_o), .dev_oe(port_b_lines_oe), .ext(ext_b),
		.pin(port_b_lines_i));
	far_side side_c (.dev_o(port_c_lines_o), .dev_oe(port_c_lines_oe), .ext(ext_c),
		.pin(port_c_lines_i));
	far_side side_d (.dev_o(port_d_lines_o), .dev_oe(port_d_lines_oe), .ext(ext_d),
		.pin(port_d_lines_i));
	quad_channel_pin_function_mux #(.CFGMEM_HALF(2)) quad_channel_pin_function_mux_inst (.*);

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_p, w_p;
		aw_p = 1;
		w_p = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			aw_p = aw_p && !s_axi_awready;
			w_p = w_p && !s_axi_wready;
			s_axi_awvalid <= aw_p;
			s_axi_wvalid <= w_p;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		`CHK(s_axi_bresp, er)
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, er)
	endtask

	task automatic setup(input logic bb);
		setup_chan <= 2'h2;
		setup_bitbang <= bb;
		setup_valid <= 1;
		@(posedge aclk);
		setup_valid <= 0;
		@(posedge aclk);
		@(posedge aclk);
	endtask

	initial begin
		repeat (3000) @(posedge aclk);
		n_fail++;
		close_out;
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, link_suspended, setup_valid} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, setup_chan, setup_bitbang} = 0;
		{s_axi_bready, s_axi_rready, cfgmem_present, cfgmem_data_i} = 4'hF;
		s_axi_wstrb = 4'hF;
		{uart_txd, uart_rts_n, uart_dtr_n, uart_line_driver_enable} = 16'h40F4;
		{engine_aux_out, engine_aux_oe, eng_sck, eng_dout, eng_cs} = 22'h30E859;
		bb_out = 32'h12345678;
		bb_oe = 32'hF00FA500;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		`CHK(port_a_lines_oe, 8'h95)
		rd(`REG_MODE, {24'h000000, `MODE_RESET}, 2'h0);
		rd(8'h10, 32'h0, 2'h2);
		wr(8'h10, 32'h1, 2'h2);
		wr(`REG_MODE, 32'h86, 2'h0);
		`CHK(port_a_lines_oe, 8'h1B)
		`CHK({port_a_lines_o[3], port_a_lines_o[1:0]}, 3'b101)
		`CHK({engine_aux_in[3:0], eng_din[0]}, 5'h07)
		`CHK(port_b_lines_oe, bb_oe[15:8])
		`CHK(bb_in[15:8], (bb_out[15:8] & bb_oe[15:8]) | (ext_b & ~bb_oe[15:8]))
		`CHK(port_d_lines_oe, 8'h95)
		`CHK({port_c_lines_o[7], port_c_lines_o[4], port_c_lines_o[2:0]}, 5'h19)
		`CHK({carrier_detect_n[2], uart_dsr_n[2], uart_cts_n[2]}, {ext_c[6:5], ext_c[3]})
		`CHK(uart_rxd[2], ext_c[1])
		wr(`REG_CFG, 32'h3, 2'h0);
		`CHK(port_c_lines_oe, 8'h15)
		`CHK(bell_wake_n[2], ext_c[7])
		setup(1'b1);
		`CHK(port_c_lines_oe, bb_oe[23:16])
		setup(1'b0);
		`CHK(port_c_lines_oe, 8'h15)
		ext_c[7] <= 0;
		link_suspended <= 1;
		// Let the registered status outputs settle before reading them
		repeat (2) @(posedge aclk);
		rd(`REG_STATUS, 32'h1D, 2'h0);
		link_suspended <= 0;
		ext_c[7] <= 1;
		wr(`REG_CFG, 32'h4, 2'h0);
		`CHK({power_enable_n, suspend_n, resume_req}, 3'b010)
		wr(`REG_CFGMEM, 32'h3, 2'h0);
		`CHK({cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_oe}, 3'b111)
		`CHK({cfgmem_select_o, cfgmem_data_o}, 2'b10)
		rd(`REG_CFGMEM, 32'hB, 2'h0);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		`CHK({cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_oe}, 3'b000)
		`CHK(port_a_lines_oe, 8'h95)
		aresetn <= 1;
		@(posedge aclk);
		`CHK({cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_oe}, 3'b000)
		@(posedge aclk);
		`CHK({cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_oe}, 3'b110)
		close_out;
	end
endmodule
